/* ssq_sequencer.sv */
/*
  Timing and control sequencer of a 10-bit successive-approximation converter,
  with its Avalon-MM register slave.
  Assumes the analog core samples on SAMPLE_O and presents its result on SAR_RESULT_I
  when the conversion ends; sleep status comes from logic on the same clock.
*/
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module ssq_sequencer (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic TRIGGER_I,
  input wire logic CPU_HALTED_I,
  input wire logic [1:0] SLEEP_MODE_I,
  input wire logic [9:0] SAR_RESULT_I,
  output logic ANALOG_ENABLE_O,
  output logic CONV_CLK_O,
  output logic SAMPLE_O,
  output logic [3:0] CHAN_SEL_O,
  output logic REF_SEL_O,
  output logic IRQ_O
);

  // ============================================================
  // Declarations
  logic en_reg, start_reg, auto_reg, done_reg, ie_reg, free_reg;
  logic [2:0] div_reg;
  ssq_pkg::ssq_sel_type sel_tmp_reg, sel_live_reg;
  logic [9:0] result_reg;
  logic lock_reg, first_reg, phase_reg, halted_prev_reg;
  logic [6:0] pre_reg;
  logic [5:0] hc_reg;
  ssq_pkg::ssq_state_type state_reg;
  ssq_pkg::ssq_mode_type mode_reg;
  logic trig_s1_reg, trig_s2_reg, trig_s3_reg, trig_lvl_reg;
  logic wait_reg, sample_reg, irq_reg;
  logic [31:0] rdata_reg;

  logic wr, rd, half_tick, rise_tick, idle, trig_rise, trig_start, sleep_start;
  logic conv_end, free_restart, last_cycle;
  logic [6:0] hmask;

  // ============================================================
  // Bus access and timing decode
  assign wr = AVS_WRITE_I & ~wait_reg;
  assign rd = AVS_READ_I & ~wait_reg;
  assign hmask = ssq_pkg::ssq_half_mask(div_reg);
  assign half_tick = ((pre_reg & hmask) == hmask);
  assign rise_tick = half_tick & ~phase_reg;
  assign idle = (state_reg == ssq_pkg::ST_IDLE);
  // The level only moves once the second and third stages agree.
  assign trig_rise = (trig_s2_reg == trig_s3_reg) & trig_s3_reg & ~trig_lvl_reg;
  // Edges while busy are dropped, and a held level never re-arms.
  assign trig_start = en_reg & auto_reg & ~free_reg & trig_rise & idle;
  // Only idle and noise-reduction sleep start a conversion; other modes leave the
  // converter running as it was.
  assign sleep_start = en_reg & idle & ~auto_reg & ie_reg & ~start_reg & CPU_HALTED_I
    & ~halted_prev_reg & (SLEEP_MODE_I == ssq_pkg::SLP_IDLE
    || SLEEP_MODE_I == ssq_pkg::SLP_NOISE);
  assign conv_end = (state_reg == ssq_pkg::ST_CONV) & half_tick
    & (hc_reg == ssq_pkg::ssq_total(mode_reg) - 6'h01);
  assign free_restart = conv_end & auto_reg & free_reg;
  assign last_cycle = hc_reg >= ssq_pkg::ssq_total(mode_reg) - 6'h02;

  // ============================================================
  // Avalon-MM slave: every access is answered one cycle after it appears.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(wait_reg & (AVS_READ_I | AVS_WRITE_I));
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_reg <= ssq_pkg::RST_RDATA;
    end else if (wait_reg & AVS_READ_I) begin
      rdata_reg <= ssq_pkg::RST_RDATA;
      unique case (AVS_ADDRESS_I)
        ssq_pkg::OFS_CTRL_A: begin
          rdata_reg[ssq_pkg::BIT_ENABLE] <= en_reg;
          rdata_reg[ssq_pkg::BIT_START] <= start_reg | ~idle;
          rdata_reg[ssq_pkg::BIT_AUTO] <= auto_reg;
          rdata_reg[ssq_pkg::BIT_DONE] <= done_reg;
          rdata_reg[ssq_pkg::BIT_IE] <= ie_reg;
          rdata_reg[ssq_pkg::BIT_DIV_LSB +: 3] <= div_reg;
        end
        ssq_pkg::OFS_CTRL_B: rdata_reg[ssq_pkg::BIT_FREE] <= free_reg;
        ssq_pkg::OFS_SELECT: begin
          rdata_reg[ssq_pkg::BIT_REF] <= sel_tmp_reg.ref_sel;
          rdata_reg[ssq_pkg::BIT_CHAN_LSB +: 4] <= sel_tmp_reg.chan;
        end
        ssq_pkg::OFS_RES_LO: rdata_reg[7:0] <= result_reg[7:0];
        ssq_pkg::OFS_RES_HI: rdata_reg[1:0] <= result_reg[9:8];
        ssq_pkg::OFS_STATUS: begin
          rdata_reg[ssq_pkg::BIT_BUSY] <= ~idle;
          rdata_reg[ssq_pkg::BIT_LOCK] <= lock_reg;
        end
        default: rdata_reg <= ssq_pkg::RST_RDATA;
      endcase
    end
  end

  // ============================================================
  // Control registers
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      en_reg <= 1'b0;
      auto_reg <= 1'b0;
      ie_reg <= 1'b0;
      div_reg <= ssq_pkg::RST_DIV;
      free_reg <= 1'b0;
      sel_tmp_reg <= '0;
    end else if (wr) begin
      if (AVS_ADDRESS_I == ssq_pkg::OFS_CTRL_A) begin
        en_reg <= AVS_WRITEDATA_I[ssq_pkg::BIT_ENABLE];
        auto_reg <= AVS_WRITEDATA_I[ssq_pkg::BIT_AUTO];
        ie_reg <= AVS_WRITEDATA_I[ssq_pkg::BIT_IE];
        div_reg <= AVS_WRITEDATA_I[ssq_pkg::BIT_DIV_LSB +: 3];
      end
      if (AVS_ADDRESS_I == ssq_pkg::OFS_CTRL_B) begin
        free_reg <= AVS_WRITEDATA_I[ssq_pkg::BIT_FREE];
      end
      if (AVS_ADDRESS_I == ssq_pkg::OFS_SELECT) begin
        sel_tmp_reg.ref_sel <= AVS_WRITEDATA_I[ssq_pkg::BIT_REF];
        sel_tmp_reg.chan <= AVS_WRITEDATA_I[ssq_pkg::BIT_CHAN_LSB +: 4];
      end
    end
  end

  // A written one sets the start bit and wins over a same-cycle hardware clear.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      start_reg <= 1'b0;
    end else if (!en_reg) begin
      start_reg <= 1'b0;
    end else if ((wr && AVS_ADDRESS_I == ssq_pkg::OFS_CTRL_A
                 && AVS_WRITEDATA_I[ssq_pkg::BIT_START]) || sleep_start) begin
      start_reg <= 1'b1;
    end else if (conv_end && !free_restart) begin
      start_reg <= 1'b0;
    end
  end

  // Done flag: hardware set beats a software clear in the same cycle.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      done_reg <= 1'b0;
    end else if (conv_end) begin
      done_reg <= 1'b1;
    end else if (wr && AVS_ADDRESS_I == ssq_pkg::OFS_CTRL_A
                 && AVS_WRITEDATA_I[ssq_pkg::BIT_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // The request follows the sticky flag, so an early wake cannot swallow it.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= done_reg & ie_reg;
    end
  end

  // ============================================================
  // Prescaler and trigger synchroniser
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pre_reg <= 7'h00;
      phase_reg <= 1'b0;
    end else if (!en_reg || trig_start) begin
      pre_reg <= 7'h00;
      phase_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 7'h01;
      phase_reg <= phase_reg ^ half_tick;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
      trig_lvl_reg <= 1'b0;
      halted_prev_reg <= 1'b0;
    end else begin
      trig_s1_reg <= TRIGGER_I;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      if (trig_s2_reg == trig_s3_reg) begin
        trig_lvl_reg <= trig_s3_reg;
      end
      halted_prev_reg <= CPU_HALTED_I;
    end
  end

  // ============================================================
  // Conversion sequencer
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg <= ssq_pkg::ST_IDLE;
      mode_reg <= ssq_pkg::MD_FIRST;
      hc_reg <= 6'h00;
    end else if (!en_reg) begin
      state_reg <= ssq_pkg::ST_IDLE;
      hc_reg <= 6'h00;
    end else begin
      unique case (state_reg)
        ssq_pkg::ST_IDLE: begin
          hc_reg <= 6'h00;
          if (trig_start) begin
            state_reg <= ssq_pkg::ST_CONV;
            mode_reg <= first_reg ? ssq_pkg::MD_FIRST : ssq_pkg::MD_AUTO;
          end else if (start_reg || sleep_start) begin
            state_reg <= ssq_pkg::ST_WAIT;
          end
        end
        ssq_pkg::ST_WAIT: begin
          if (rise_tick) begin
            state_reg <= ssq_pkg::ST_CONV;
            mode_reg <= first_reg ? ssq_pkg::MD_FIRST : ssq_pkg::MD_NORMAL;
          end
        end
        ssq_pkg::ST_CONV: begin
          if (conv_end) begin
            hc_reg <= 6'h00;
            if (free_restart) begin
              mode_reg <= ssq_pkg::MD_FREE;
            end else begin
              state_reg <= ssq_pkg::ST_IDLE;
            end
          end else if (half_tick) begin
            hc_reg <= hc_reg + 6'h01;
          end
        end
        default: state_reg <= ssq_pkg::ST_IDLE;
      endcase
    end
  end

  // The long first conversion is owed once per enable.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      first_reg <= 1'b1;
    end else if (!en_reg) begin
      first_reg <= 1'b1;
    end else if (conv_end) begin
      first_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sample_reg <= 1'b0;
    end else begin
      sample_reg <= (state_reg == ssq_pkg::ST_CONV) & half_tick
        & (hc_reg == ssq_pkg::ssq_sample(mode_reg) - 6'h01);
    end
  end

  // Selection is frozen from start to the last cycle so the sampling capacitor
  // settles on one input; a change made meanwhile lands on the next conversion.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sel_live_reg <= '0;
    end else if (en_reg && (state_reg != ssq_pkg::ST_CONV || last_cycle)) begin
      sel_live_reg <= sel_tmp_reg;
    end
  end

  // ============================================================
  // Result registers with low-then-high read lock
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lock_reg <= 1'b0;
    end else if (rd && AVS_ADDRESS_I == ssq_pkg::OFS_RES_LO) begin
      lock_reg <= 1'b1;
    end else if (rd && AVS_ADDRESS_I == ssq_pkg::OFS_RES_HI) begin
      lock_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      result_reg <= 10'h000;
    end else if (conv_end && !lock_reg) begin
      result_reg <= SAR_RESULT_I;
    end
  end

  assign AVS_READDATA_O = rdata_reg;
  assign AVS_WAITREQUEST_O = wait_reg;
  assign ANALOG_ENABLE_O = en_reg;
  assign CONV_CLK_O = phase_reg;
  assign SAMPLE_O = sample_reg;
  assign CHAN_SEL_O = sel_live_reg.chan;
  assign REF_SEL_O = sel_live_reg.ref_sel;
  assign IRQ_O = irq_reg;

  // ============================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  chk_presc_held: assert property (!en_reg |=> pre_reg == 7'h00)
    else $error("prescaler ran while disabled");
  chk_start_edge: assert property (
    state_reg == ssq_pkg::ST_WAIT && en_reg && rise_tick |=> state_reg == ssq_pkg::ST_CONV)
    else $error("conversion did not start on converter clock edge");
  chk_normal_len: assert property (
    conv_end && mode_reg == ssq_pkg::MD_NORMAL |-> hc_reg == 6'h19)
    else $error("normal conversion length wrong");
  chk_first_len: assert property (
    conv_end && mode_reg == ssq_pkg::MD_FIRST |-> hc_reg == 6'h31)
    else $error("first conversion length wrong");
  chk_start_cleared: assert property (
    conv_end && !free_restart && !wr && !sleep_start |=> !start_reg)
    else $error("start bit not cleared at completion");
  chk_trig_reset: assert property (trig_start |=> pre_reg == 7'h00 ##1 pre_reg == 7'h01)
    else $error("trigger did not reset prescaler");
  chk_auto_sample: assert property (
    sample_reg && mode_reg == ssq_pkg::MD_AUTO |-> $past(hc_reg) == 6'h03)
    else $error("triggered sample point wrong");
  chk_free_run: assert property (
    free_restart && en_reg |=> state_reg == ssq_pkg::ST_CONV && start_reg
    && mode_reg == ssq_pkg::MD_FREE && hc_reg == 6'h00)
    else $error("free running did not restart");
  chk_sel_locked: assert property (
    state_reg == ssq_pkg::ST_CONV && !last_cycle && $past(state_reg) == ssq_pkg::ST_CONV
    |-> $stable(sel_live_reg))
    else $error("selection changed mid conversion");
  chk_busy_reads_one: assert property (
    wait_reg && AVS_READ_I && AVS_ADDRESS_I == ssq_pkg::OFS_CTRL_A && !idle
    |=> rdata_reg[ssq_pkg::BIT_START])
    else $error("start bit read low while busy");
  chk_trig_ignored: assert property (
    trig_rise && state_reg == ssq_pkg::ST_CONV && !conv_end |=> $stable(mode_reg)
    && pre_reg == $past(pre_reg) + 7'h01 || !$past(en_reg))
    else $error("trigger edge disturbed running conversion");
  chk_result_held: assert property (
    conv_end && lock_reg |=> $stable(result_reg) && done_reg)
    else $error("locked result overwritten or done missing");
  chk_sleep_start: assert property (
    sleep_start |=> state_reg == ssq_pkg::ST_WAIT && start_reg)
    else $error("sleep did not start conversion");
  chk_irq_follow: assert property (done_reg && ie_reg |=> IRQ_O)
    else $error("completion request missing");

  cov_first: cover property (conv_end && mode_reg == ssq_pkg::MD_FIRST);
  cov_auto: cover property (conv_end && mode_reg == ssq_pkg::MD_AUTO);
  cov_free: cover property (free_restart ##1 mode_reg == ssq_pkg::MD_FREE);
  cov_lost: cover property (conv_end && lock_reg);

endmodule : ssq_sequencer

`default_nettype wire

/* ssq_pkg.sv */
/*
  Constants, types and timing decode shared by the conversion sequencer.
  Assumes a 125 MHz core clock and a 32-bit Avalon-MM register bus with byte addresses.
*/
// ============================================================
// How it works
// - Prescaler runs while enable is set and is held reset while it is low.
// - A written start begins converting on the next converter clock rising edge.
// - Normal conversion lasts 13 converter cycles, sample-and-hold at 1.5 cycles.
// - First conversion after enabling lasts 25 cycles, sample-and-hold at 13.5.
// - Completion stores result, sets done flag, clears start bit in single mode.
// - A trigger event resets the prescaler so trigger-to-start delay is fixed.
// - Triggered conversion samples 2 cycles after trigger, lasts 13.5 cycles.
// - Free running restarts at completion with start bit high; 2.5 and 14 cycles.
// - Channel and reference pass a holding register, locked once converting.
// - Selection tracking resumes in the last converter cycle before completion.
// - A selection change made in a safe window affects the next conversion.
// - Enabled idle single mode with interrupt on starts converting once CPU halts in idle or noise-reduction sleep.
// - Completion still raises the interrupt request after an early wake.
// - Other sleep modes do not disable the converter automatically.
// - Start bit reads one throughout any conversion; hardware clears it in single mode.
// - Trigger edges during conversion are ignored; a held trigger does not restart.
// - Low byte read blocks result updates until high byte read; done still set.

package ssq_pkg;

  // Register byte offsets.
  localparam logic [4:0] OFS_CTRL_A = 5'h00;
  localparam logic [4:0] OFS_CTRL_B = 5'h04;
  localparam logic [4:0] OFS_SELECT = 5'h08;
  localparam logic [4:0] OFS_RES_LO = 5'h0C;
  localparam logic [4:0] OFS_RES_HI = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;

  // Field positions of converter_control_status_a.
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_AUTO = 5;
  localparam int BIT_DONE = 4;
  localparam int BIT_IE = 3;
  localparam int BIT_DIV_LSB = 0;
  // Other fields.
  localparam int BIT_FREE = 0;
  localparam int BIT_REF = 6;
  localparam int BIT_CHAN_LSB = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_LOCK = 0;

  // Reset values.
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // Sleep mode codes reported by the core.
  localparam logic [1:0] SLP_IDLE = 2'h1;
  localparam logic [1:0] SLP_NOISE = 2'h2;

  // Conversion timing in half converter-clock periods.
  localparam logic [5:0] HALF_TOT_FIRST = 6'h32;  // 25 cycles
  localparam logic [5:0] HALF_TOT_NORMAL = 6'h1A; // 13 cycles
  localparam logic [5:0] HALF_TOT_AUTO = 6'h1B;   // 13.5 cycles
  localparam logic [5:0] HALF_TOT_FREE = 6'h1C;   // 14 cycles
  localparam logic [5:0] HALF_SH_FIRST = 6'h1B;   // 13.5 cycles
  localparam logic [5:0] HALF_SH_NORMAL = 6'h03;  // 1.5 cycles
  localparam logic [5:0] HALF_SH_AUTO = 6'h04;    // 2 cycles
  localparam logic [5:0] HALF_SH_FREE = 6'h05;    // 2.5 cycles

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } ssq_state_type;

  typedef enum logic [1:0] {
    MD_FIRST = 2'b00,
    MD_NORMAL = 2'b01,
    MD_AUTO = 2'b10,
    MD_FREE = 2'b11
  } ssq_mode_type;

  typedef struct packed {
    logic ref_sel;
    logic [3:0] chan;
  } ssq_sel_type;

  // Mask of prescaler bits below the selected tap: the half period minus one.
  function automatic logic [6:0] ssq_half_mask(input logic [2:0] div);
    unique case (div)
      3'h0, 3'h1: ssq_half_mask = 7'h00;
      3'h2: ssq_half_mask = 7'h01;
      3'h3: ssq_half_mask = 7'h03;
      3'h4: ssq_half_mask = 7'h07;
      3'h5: ssq_half_mask = 7'h0F;
      3'h6: ssq_half_mask = 7'h1F;
      3'h7: ssq_half_mask = 7'h3F;
    endcase
  endfunction : ssq_half_mask

  function automatic logic [5:0] ssq_total(input ssq_mode_type md);
    unique case (md)
      MD_FIRST: ssq_total = HALF_TOT_FIRST;
      MD_NORMAL: ssq_total = HALF_TOT_NORMAL;
      MD_AUTO: ssq_total = HALF_TOT_AUTO;
      MD_FREE: ssq_total = HALF_TOT_FREE;
    endcase
  endfunction : ssq_total

  function automatic logic [5:0] ssq_sample(input ssq_mode_type md);
    unique case (md)
      MD_FIRST: ssq_sample = HALF_SH_FIRST;
      MD_NORMAL: ssq_sample = HALF_SH_NORMAL;
      MD_AUTO: ssq_sample = HALF_SH_AUTO;
      MD_FREE: ssq_sample = HALF_SH_FREE;
    endcase
  endfunction : ssq_sample

endpackage : ssq_pkg

/* ssq_analog_model.sv */
/*
  Behavioural analog core that faces the sequencer.
  Assumes one core clock; the result code packs the selection seen at the sample pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module ssq_analog_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sample_i,
  input wire logic enable_i,
  input wire logic [3:0] chan_i,
  input wire logic ref_i,
  output logic [9:0] result_o
);
  logic [9:0] held_reg;

  // The code carries channel and reference so a result shows which selection it used.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held_reg <= 10'h000;
    end else if (sample_i) begin
      held_reg <= {ref_i, 1'b1, chan_i, 4'hC};
    end
  end

  // A powered-down core holds nothing, so it shows a pattern the bench would not expect.
  always_comb result_o = enable_i ? held_reg : ~held_reg;
endmodule : ssq_analog_model

`default_nettype wire

/* tb_top.sv */
/*
  Self-checking bench for the conversion sequencer: registers, timing, triggers, sleep.
  Assumes divider 7, so half a converter period is 64 core clocks.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_top;
  // ============================================================
  // Signals and instances
  localparam int HP = 64;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic trig = 1'b0;
  logic halted = 1'b0;
  logic [1:0] slp = 2'h0;
  logic [31:0] rdat;
  logic wreq;
  logic aen;
  logic cclk;
  logic smp;
  logic [3:0] chan;
  logic refs;
  logic irq;
  logic irq_d = 1'b0;
  logic [9:0] res;
  logic [31:0] q;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ev[2] = '{0, 0};
  int tev[2] = '{0, 0};
  int tprev = 0;
  int t0;
  int n0;

  ssq_sequencer dut (.CORE_CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .TRIGGER_I(trig), .CPU_HALTED_I(halted),
    .SLEEP_MODE_I(slp), .SAR_RESULT_I(res), .ANALOG_ENABLE_O(aen), .CONV_CLK_O(cclk),
    .SAMPLE_O(smp), .CHAN_SEL_O(chan), .REF_SEL_O(refs), .IRQ_O(irq));
  ssq_analog_model partner (.clk_i(clk), .nrst_i(nrst), .sample_i(smp), .enable_i(aen),
    .chan_i(chan), .ref_i(refs), .result_o(res));

  initial forever #4 clk = ~clk;

  // Event 0 is a sample pulse, event 1 a rising interrupt request.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_d <= irq;
    if (smp === 1'b1) begin
      ev[0] <= ev[0] + 1;
      tev[0] <= cyc;
      tprev <= tev[0];
    end
    if (irq === 1'b1 && irq_d !== 1'b1) begin
      ev[1] <= ev[1] + 1;
      tev[1] <= cyc;
    end
  end

  // ============================================================
  // Helpers
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : acc

  task automatic wait_ev(input int k, input int lim);
    int c;
    int i;
    c = ev[k];
    for (i = 0; i < lim && ev[k] == c; i++) begin
      @(posedge clk);
    end
    if (ev[k] == c) begin
      fails++;
      report_and_stop();
    end
  endtask : wait_ev

  function automatic logic in_rng(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction : in_rng

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ============================================================
  // Scenarios
  task automatic s_first();
    acc(1'b0, 5'h1C, 32'h0);
    `CHK(q, 32'h0000_0000)
    acc(1'b1, ssq_pkg::OFS_SELECT, 32'h43);
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'h8F);
    repeat (2) @(posedge clk);
    `CHK({aen, refs, chan}, 6'h33)
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'hCF);
    t0 = cyc;
    acc(1'b0, ssq_pkg::OFS_CTRL_A, 32'h0);
    `CHK(q[6], 1'b1)
    wait_ev(0, 40 * HP);
    `CHK(in_rng(tev[0] - t0, 27 * HP, 29 * HP + 4), 1'b1)
    acc(1'b1, ssq_pkg::OFS_SELECT, 32'h05);
    repeat (2) @(posedge clk);
    `CHK({refs, chan}, 5'h13)
    wait_ev(1, 30 * HP);
    `CHK(in_rng(tev[1] - tev[0], 23 * HP, 23 * HP + 2), 1'b1)
    acc(1'b0, ssq_pkg::OFS_CTRL_A, 32'h0);
    `CHK(q[7:4], 4'h9)
    `CHK({refs, chan}, 5'h05)
    acc(1'b0, ssq_pkg::OFS_RES_LO, 32'h0);
    `CHK(q[7:0], 8'h3C)
    acc(1'b0, ssq_pkg::OFS_RES_HI, 32'h0);
    `CHK(q[1:0], 2'h3)
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'h9F);
  endtask : s_first

  // The low-byte read here locks the result across the following conversion.
  task automatic s_normal();
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'hCF);
    t0 = cyc;
    wait_ev(0, 8 * HP);
    `CHK(in_rng(tev[0] - t0, 3 * HP, 5 * HP + 4), 1'b1)
    wait_ev(1, 30 * HP);
    `CHK(in_rng(tev[1] - tev[0], 23 * HP, 23 * HP + 2), 1'b1)
    acc(1'b0, ssq_pkg::OFS_RES_LO, 32'h0);
    `CHK(q[7:0], 8'h5C)
    acc(1'b1, ssq_pkg::OFS_SELECT, 32'h46);
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'h9F);
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'hCF);
    wait_ev(1, 40 * HP);
    acc(1'b0, ssq_pkg::OFS_CTRL_A, 32'h0);
    `CHK(q[4], 1'b1)
    acc(1'b0, ssq_pkg::OFS_RES_HI, 32'h0);
    `CHK(q[1:0], 2'h1)
    acc(1'b0, ssq_pkg::OFS_RES_LO, 32'h0);
    `CHK(q[7:0], 8'h5C)
    acc(1'b0, ssq_pkg::OFS_STATUS, 32'h0);
    `CHK(q[1:0], 2'h1)
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'h9F);
  endtask : s_normal

  task automatic s_auto();
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'hAF);
    n0 = ev[0];
    trig <= 1'b1;
    t0 = cyc;
    wait_ev(0, 8 * HP);
    `CHK(in_rng(tev[0] - t0, 4 * HP, 4 * HP + 8), 1'b1)
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    trig <= 1'b1;
    wait_ev(1, 30 * HP);
    repeat (30 * HP) @(posedge clk);
    `CHK(ev[0] - n0, 1)
    trig <= 1'b0;
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'h9F);
  endtask : s_auto

  task automatic s_free();
    acc(1'b1, ssq_pkg::OFS_CTRL_B, 32'h1);
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'hEF);
    wait_ev(0, 8 * HP);
    wait_ev(0, 32 * HP);
    `CHK(tev[0] - tprev, 28 * HP)
    acc(1'b0, ssq_pkg::OFS_CTRL_A, 32'h0);
    `CHK(q[6], 1'b1)
    acc(1'b0, ssq_pkg::OFS_STATUS, 32'h0);
    `CHK(q[1:0], 2'h3)
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'h0);
    acc(1'b1, ssq_pkg::OFS_CTRL_B, 32'h0);
    repeat (2 * HP) @(posedge clk);
    `CHK({aen, cclk}, 2'b00)
  endtask : s_free

  task automatic s_sleep();
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'h9F);
    slp <= 2'h3;
    halted <= 1'b1;
    n0 = ev[0];
    repeat (4 * HP) @(posedge clk);
    `CHK(ev[0], n0)
    halted <= 1'b0;
    @(posedge clk);
    slp <= 2'h2;
    halted <= 1'b1;
    wait_ev(0, 40 * HP);
    `CHK(ev[0] - n0, 1)
    halted <= 1'b0;
    wait_ev(1, 30 * HP);
    `CHK(irq, 1'b1)
    acc(1'b1, ssq_pkg::OFS_CTRL_A, 32'h9F);
  endtask : s_sleep

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    s_first();
    s_normal();
    s_auto();
    s_free();
    s_sleep();
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
